// >>> logic/pdi_pkg.sv
// shared constants and types of the processor dram interface
package pdi_pkg;

	// ---------------------------------------------------------------
	// widths and memory map
	// ---------------------------------------------------------------
	localparam int           ADDR_W      = 16;
	localparam int           DATA_W      = 16;
	localparam int           ROW_W       = 7;
	localparam int           COL_W       = 7;
	localparam int           PROM_AW     = 12;
	localparam int           DRAM_WORDS  = 16384;
	localparam int           PROM_WORDS  = 4096;
	localparam int           ROW_COUNT   = 128;
	localparam logic [15:0]  DRAM_TOP    = 16'h3fff;
	localparam logic [15:0]  UNUSED_HI   = 16'hf7ff;
	localparam logic [15:0]  PROM_BASE   = 16'hf800;
	localparam logic [15:0]  PRO_BASE_DEF = 16'h0000;
	localparam logic [15:0]  PRO_LIM_DEF  = 16'h00ff;
	localparam logic [15:0]  OSD_BASE_DEF = 16'h0100;
	localparam logic [15:0]  OSD_LIM_DEF  = 16'h01ff;

	// ---------------------------------------------------------------
	// timing
	// ---------------------------------------------------------------
	localparam int CLK_PERIOD_NS   = 100;
	localparam int PROC_MIN_NS     = 222;
	localparam int PROC_TYP_NS     = 243;
	localparam int PAGE_MIN_NS     = 170;
	localparam int RAND_MIN_NS     = 375;
	localparam int DWELL_US        = 10;
	localparam int REFRESH_MS      = 2;
	// four intervals of one mclk each
	localparam int INTERVALS       = 4;
	localparam int PAGE_CYC        = INTERVALS;
	localparam int RAND_CYC        = 2 * INTERVALS;
	localparam int HOLD_CYC        = RAND_CYC - PAGE_CYC;
	localparam int PAGE_MIN_CYC    = (PAGE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RAND_MIN_CYC    = (RAND_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int PROC_MIN_CYC    = (PROC_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DWELL_CYC       = (DWELL_US * 1000) / CLK_PERIOD_NS;
	localparam int DWELL_W         = 7;
	localparam int REFRESH_CYC_DEF = (REFRESH_MS * 1000000) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		PDI_IDLE,
		PDI_PAGE,
		PDI_RAND,
		PDI_ROM
	} pdi_state_t;

endpackage : pdi_pkg

// >>> logic/pdi_timing_gen.sv
// two-phase processor clock generator with random-access stretch
`timescale 1ns/1ps
module pdi_timing_gen
	import pdi_pkg::*;
(
	input  wire logic mclk,
	input  wire logic rst_b,
	input  wire logic stretch,
	output logic      phase0_clock,
	output logic      phase1_clock,
	output logic      last_interval
);

	typedef struct packed {
		logic [1:0] t;
		logic       holding;
		logic [2:0] hcnt;
		logic       ph0;
		logic       ph1;
	} pdi_tg_t;

	pdi_tg_t q_ff;
	pdi_tg_t nxt_q;
	logic [1:0] t_inc;

	always_comb begin
		nxt_q = q_ff;
		t_inc = q_ff.t + 2'h1;
		if (q_ff.holding) begin
			if (q_ff.hcnt == 3'(HOLD_CYC - 1)) begin
				nxt_q.holding = 1'b0;
				nxt_q.t       = 2'h0;
				nxt_q.ph0     = 1'b1;
				nxt_q.ph1     = 1'b0;
			end else begin
				nxt_q.hcnt = q_ff.hcnt + 3'h1;
			end
		end else if (q_ff.t == 2'h3 && stretch) begin
			// clocks frozen low for a second processor cycle
			nxt_q.holding = 1'b1;
			nxt_q.hcnt    = 3'h0;
		end else begin
			nxt_q.t   = t_inc;
			nxt_q.ph0 = (t_inc == 2'h0) || (t_inc == 2'h1);
			nxt_q.ph1 = (t_inc == 2'h2);
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			q_ff <= '{t: 2'h0, holding: 1'b0, hcnt: 3'h0, ph0: 1'b1, ph1: 1'b0};
		end else begin
			q_ff <= nxt_q;
		end
	end

	assign phase0_clock  = q_ff.ph0;
	assign phase1_clock  = q_ff.ph1;
	// high in the mclk just before t1 begins; cycle is 4 mclk = 400 ns
	assign last_interval = (q_ff.holding && q_ff.hcnt == 3'(HOLD_CYC - 1)) ||
		(!q_ff.holding && q_ff.t == 2'h3 && !stretch);

endmodule : pdi_timing_gen

// >>> logic/pdi_dram_if.sv
// processor dram/prom interface: page or random cycles, refresh timer, protection
//
// Operation
// - serve 16K dram words and 4K prom; only 2K prom words (f800-ffff, prom_addr 800-fff) are mapped here
// - row on ras fall, then column on cas
// - same row: page cycles, new column only
// - after 10 us page, precharge, next random
// - page >= 170 ns, random >= 375 ns
// - page one processor cycle, random two
// - page or random chosen by hardware
// - word or byte read, sign or zero
// - refresh request about every 2 ms
// - all 128 rows strobed during refresh
// - refresh tick drives the software clock
// - prologue, os data, unused, prom privileged
// - unauthorized privileged write becomes read, fault
// - page fault stalls clock during random access
// - two phases give four intervals per cycle
// - processor cycle at least 222 ns
`timescale 1ns/1ps
module pdi_dram_if
	import pdi_pkg::*;
#(
	parameter int          REFRESH_CYC = REFRESH_CYC_DEF,
	parameter logic [15:0] PRO_BASE    = PRO_BASE_DEF,
	parameter logic [15:0] PRO_LIM     = PRO_LIM_DEF,
	parameter logic [15:0] OSD_BASE    = OSD_BASE_DEF,
	parameter logic [15:0] OSD_LIM     = OSD_LIM_DEF
) (
	input  wire logic                mclk,
	input  wire logic                rst_b,
	input  wire logic                mem_req,
	input  wire logic                mem_write,
	input  wire logic [ADDR_W-1:0]   mem_addr,
	input  wire logic [DATA_W-1:0]   mem_wdata,
	input  wire logic                byte_mode,
	input  wire logic                byte_high,
	input  wire logic                sign_extend,
	input  wire logic                write_authorized,
	input  wire logic                fault_clear,
	input  wire logic                refresh_ack,
	input  wire logic [DATA_W-1:0]   dram_dq_in,
	input  wire logic [DATA_W-1:0]   prom_data,
	output logic                     mem_done,
	output logic [DATA_W-1:0]        mem_rdata,
	output logic                     protect_fault,
	output logic                     refresh_req,
	output logic                     clock_tick,
	output logic                     page_fault,
	output logic                     phase0_clock,
	output logic                     phase1_clock,
	output logic [ROW_W-1:0]         dram_addr,
	output logic                     dram_ras_n,
	output logic                     dram_cas_n,
	output logic                     dram_we_n,
	output logic [DATA_W-1:0]        dram_dq_out,
	output logic                     dram_dq_oe,
	output logic [PROM_AW-1:0]       prom_addr,
	output logic                     prom_cs_n
);

	localparam int RT_W = $clog2(REFRESH_CYC);

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	typedef struct packed {
		pdi_state_t         st;
		logic [2:0]         step;
		logic               ras_n;
		logic               cas_n;
		logic               we_n;
		logic               dq_oe;
		logic [ROW_W-1:0]   a;
		logic [DATA_W-1:0]  dq_out;
		logic [ROW_W-1:0]   row;
		logic               row_open;
		logic [DWELL_W-1:0] dwell;
		logic [RT_W-1:0]    rtmr;
		logic               rfsh;
		logic               tick;
		logic               fault;
		logic               pf;
		logic [DATA_W-1:0]  rdata;
		logic               done;
		logic               cs_n;
		logic [PROM_AW-1:0] pa;
		logic               rom_hit;
		logic               wr;
		logic               bmode;
		logic               bhi;
		logic               sx;
	} pdi_core_t;

	pdi_core_t q_ff;
	pdi_core_t nxt_q;
	logic      last;

	pdi_timing_gen u_tg (
		.mclk          (mclk),
		.rst_b         (rst_b),
		.stretch       (q_ff.pf),
		.phase0_clock  (phase0_clock),
		.phase1_clock  (phase1_clock),
		.last_interval (last)
	);

	// ---------------------------------------------------------------
	// decoding
	// ---------------------------------------------------------------
	function automatic logic pdi_priv(input logic [ADDR_W-1:0] a);
		pdi_priv = (a >= PRO_BASE && a <= PRO_LIM) ||
			(a >= OSD_BASE && a <= OSD_LIM) ||
			(a > DRAM_TOP && a <= UNUSED_HI) ||
			(a >= PROM_BASE);
	endfunction : pdi_priv

	function automatic logic [DATA_W-1:0] pdi_unpack(
		input logic [DATA_W-1:0] w,
		input logic              bmode,
		input logic              bhi,
		input logic              sx
	);
		logic [7:0] b;
		b = bhi ? w[15:8] : w[7:0];
		if (!bmode) begin
			pdi_unpack = w;
		end else begin
			pdi_unpack = {{8{sx & b[7]}}, b};
		end
	endfunction : pdi_unpack

	logic [ROW_W-1:0] req_row;
	logic [COL_W-1:0] req_col;
	logic             req_dram;
	logic             req_wr;
	logic             blocked;
	logic             page_ok;

	assign req_row  = mem_addr[COL_W +: ROW_W];
	assign req_col  = mem_addr[COL_W-1:0];
	assign req_dram = (mem_addr <= DRAM_TOP);
	assign blocked  = mem_write && !write_authorized && pdi_priv(mem_addr);
	assign req_wr   = mem_write && !blocked;
	// page access only if it can finish inside the dwell window
	assign page_ok  = q_ff.row_open && (q_ff.row == req_row) &&
		(q_ff.dwell <= DWELL_W'(DWELL_CYC - PAGE_CYC));

	// ---------------------------------------------------------------
	// next state
	// ---------------------------------------------------------------
	always_comb begin
		nxt_q      = q_ff;
		nxt_q.done = 1'b0;
		nxt_q.tick = 1'b0;

		// refresh timer; same tick feeds the software clock
		if (q_ff.rtmr == RT_W'(REFRESH_CYC - 1)) begin
			nxt_q.rtmr = '0;
			nxt_q.tick = 1'b1;
		end else begin
			nxt_q.rtmr = q_ff.rtmr + RT_W'(1);
		end
		if (refresh_ack) begin
			nxt_q.rfsh = 1'b0;
		end
		if (q_ff.rtmr == RT_W'(REFRESH_CYC - 1)) begin
			nxt_q.rfsh = 1'b1;
		end

		if (fault_clear) begin
			nxt_q.fault = 1'b0;
		end

		if (q_ff.row_open && q_ff.dwell != {DWELL_W{1'b1}}) begin
			nxt_q.dwell = q_ff.dwell + DWELL_W'(1);
		end

		unique case (q_ff.st)
			PDI_IDLE: begin
				if (q_ff.row_open && q_ff.dwell > DWELL_W'(DWELL_CYC - PAGE_CYC)) begin
					nxt_q.ras_n    = 1'b1;
					nxt_q.row_open = 1'b0;
				end
			end
			PDI_PAGE: begin
				nxt_q.step = q_ff.step + 3'h1;
				if (q_ff.step == 3'h0) begin
					nxt_q.cas_n = 1'b0;
					nxt_q.we_n  = !q_ff.wr;
				end
				if (q_ff.step == 3'(PAGE_CYC - 1)) begin
					nxt_q.cas_n = 1'b1;
					nxt_q.we_n  = 1'b1;
					nxt_q.dq_oe = 1'b0;
					nxt_q.rdata = pdi_unpack(dram_dq_in, q_ff.bmode, q_ff.bhi, q_ff.sx);
					nxt_q.done  = 1'b1;
					nxt_q.st    = PDI_IDLE;
				end
			end
			PDI_RAND: begin
				nxt_q.step = q_ff.step + 3'h1;
				unique case (q_ff.step)
					3'h1: begin
						// row latched as ras falls after two precharge cycles
						nxt_q.ras_n    = 1'b0;
						nxt_q.row_open = 1'b1;
						nxt_q.dwell    = '0;
					end
					3'h2: begin
						nxt_q.a = q_ff.pa[COL_W-1:0];
					end
					3'h3: begin
						nxt_q.cas_n = 1'b0;
						nxt_q.we_n  = !q_ff.wr;
					end
					3'h7: begin
						nxt_q.cas_n = 1'b1;
						nxt_q.we_n  = 1'b1;
						nxt_q.dq_oe = 1'b0;
						nxt_q.pf    = 1'b0;
						nxt_q.rdata = pdi_unpack(dram_dq_in, q_ff.bmode, q_ff.bhi, q_ff.sx);
						nxt_q.done  = 1'b1;
						nxt_q.st    = PDI_IDLE;
					end
					default: begin
					end
				endcase
			end
			PDI_ROM: begin
				nxt_q.step = q_ff.step + 3'h1;
				// back-to-back prom reads must not keep a row open past its limit
				if (q_ff.row_open && q_ff.dwell > DWELL_W'(DWELL_CYC - PAGE_CYC)) begin
					nxt_q.ras_n    = 1'b1;
					nxt_q.row_open = 1'b0;
				end
				if (q_ff.step == 3'(PAGE_CYC - 1)) begin
					nxt_q.cs_n  = 1'b1;
					nxt_q.rdata = pdi_unpack(q_ff.rom_hit ? prom_data : '0,
						q_ff.bmode, q_ff.bhi, q_ff.sx);
					nxt_q.done  = 1'b1;
					nxt_q.st    = PDI_IDLE;
				end
			end
		endcase

		// new access taken only at the end of a processor cycle
		if (last && mem_req && (nxt_q.st == PDI_IDLE)) begin
			nxt_q.step  = 3'h0;
			nxt_q.wr    = req_wr;
			nxt_q.bmode = byte_mode;
			nxt_q.bhi   = byte_high;
			nxt_q.sx    = sign_extend;
			nxt_q.pa    = mem_addr[PROM_AW-1:0];
			if (blocked) begin
				nxt_q.fault = 1'b1;
			end
			if (!req_dram) begin
				nxt_q.st      = PDI_ROM;
				nxt_q.rom_hit = (mem_addr >= PROM_BASE);
				nxt_q.cs_n    = !(mem_addr >= PROM_BASE);
			end else begin
				nxt_q.dq_out = mem_wdata;
				nxt_q.dq_oe  = req_wr;
				if (page_ok) begin
					nxt_q.st = PDI_PAGE;
					nxt_q.a  = req_col;
				end else begin
					// any row change strobes ras, so a refresh sweep of
					// all rows runs as random cycles
					nxt_q.st       = PDI_RAND;
					nxt_q.pf       = 1'b1;
					nxt_q.ras_n    = 1'b1;
					nxt_q.row_open = 1'b0;
					nxt_q.row      = req_row;
					nxt_q.a        = req_row;
				end
			end
		end
	end

	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			q_ff       <= '0;
			q_ff.st    <= PDI_IDLE;
			q_ff.ras_n <= 1'b1;
			q_ff.cas_n <= 1'b1;
			q_ff.we_n  <= 1'b1;
			q_ff.cs_n  <= 1'b1;
		end else begin
			q_ff <= nxt_q;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign mem_done      = q_ff.done;
	assign mem_rdata     = q_ff.rdata;
	assign protect_fault = q_ff.fault;
	assign refresh_req   = q_ff.rfsh;
	assign clock_tick    = q_ff.tick;
	assign page_fault    = q_ff.pf;
	assign dram_addr     = q_ff.a;
	assign dram_ras_n    = q_ff.ras_n;
	assign dram_cas_n    = q_ff.cas_n;
	assign dram_we_n     = q_ff.we_n;
	assign dram_dq_out   = q_ff.dq_out;
	assign dram_dq_oe    = q_ff.dq_oe;
	assign prom_addr     = q_ff.pa;
	assign prom_cs_n     = q_ff.cs_n;

endmodule : pdi_dram_if

// >>> verification/pdi_chk.sv
// port checker of the processor dram interface
`timescale 1ns/1ps
module pdi_chk
	import pdi_pkg::*;
#(
	parameter int REFRESH_CYC = 40
) (
	input wire logic              mclk,
	input wire logic              rst_b,
	input wire logic              fault_clear,
	input wire logic              refresh_ack,
	input wire logic              mem_done,
	input wire logic [DATA_W-1:0] mem_rdata,
	input wire logic              protect_fault,
	input wire logic              refresh_req,
	input wire logic              clock_tick,
	input wire logic              page_fault,
	input wire logic              phase0_clock,
	input wire logic              phase1_clock,
	input wire logic              dram_ras_n,
	input wire logic              dram_cas_n,
	input wire logic              dram_we_n
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	// ----
	// helpers: tick spacing and open-row time
	// ----
	logic [15:0] gap_ff;
	logic [15:0] open_ff;
	logic        seen_ff;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			gap_ff  <= 16'h0;
			open_ff <= 16'h0;
			seen_ff <= 1'b0;
		end else begin
			gap_ff  <= clock_tick ? 16'h0 : gap_ff + 16'h1;
			open_ff <= dram_ras_n ? 16'h0 : open_ff + 16'h1;
			seen_ff <= seen_ff | clock_tick;
		end
	end
	a_done_pulse: assert property (mem_done |=> !mem_done)
		else $error("done held too long");
	a_tick_period: assert property (clock_tick && seen_ff |-> gap_ff == 16'(REFRESH_CYC - 1))
		else $error("tick spacing wrong");
	a_tick_req: assert property (clock_tick |-> ##[0:1] refresh_req)
		else $error("tick without refresh request");
	a_req_sticky: assert property (refresh_req && !refresh_ack |=> refresh_req)
		else $error("refresh request dropped");
	a_fault_sticky: assert property (protect_fault && !fault_clear |=> protect_fault)
		else $error("fault dropped");
	a_blocked_we: assert property ($rose(protect_fault) |-> dram_we_n[*4])
		else $error("blocked write strobed");
	a_cas_in_row: assert property ($fell(dram_cas_n) |-> !dram_ras_n)
		else $error("column strobe without row");
	a_pf_length: assert property ($rose(page_fault) |-> page_fault[*7])
		else $error("page fault too short");
	a_stretch_stop: assert property ($rose(page_fault) |-> ##5 (!phase0_clock && !phase1_clock)[*2])
		else $error("clock not stretched");
	a_phase_excl: assert property (!(phase0_clock && phase1_clock))
		else $error("phases overlap");
	a_rdata_hold: assert property ($changed(mem_rdata) |-> mem_done)
		else $error("read data moved without done");
	a_dwell_limit: assert property (open_ff < 16'd110)
		else $error("row open too long");
endmodule : pdi_chk

// >>> verification/pdi_mem_model.sv
// behavioural dram array and program prom beyond the interface
`timescale 1ns/1ps
module pdi_mem_model
	import pdi_pkg::*;
(
	input wire logic               mclk,
	input wire logic [ROW_W-1:0]   dram_addr,
	input wire logic               dram_ras_n,
	input wire logic               dram_cas_n,
	input wire logic               dram_we_n,
	input wire logic [DATA_W-1:0]  dram_dq_out,
	input wire logic [PROM_AW-1:0] prom_addr,
	input wire logic               prom_cs_n,
	output logic [DATA_W-1:0]      dram_dq_in,
	output logic [DATA_W-1:0]      prom_data
);
	logic [DATA_W-1:0] mem [DRAM_WORDS];
	logic [ROW_W-1:0]  row;
	logic [COL_W-1:0]  col;
	logic [DATA_W-1:0] lastd = 16'h0;
	logic [DATA_W-1:0] lastp = 16'h0;
	always @(negedge dram_ras_n) row = dram_addr;
	always @(negedge dram_cas_n) col = dram_addr;
	always @(posedge mclk) begin
		if (!dram_cas_n && !dram_we_n) mem[{row, col}] <= dram_dq_out;
		if (!dram_cas_n) lastd <= dram_dq_in;
		if (!prom_cs_n) lastp <= prom_data;
	end
	// released lines invert, so a stale sample never looks right
	assign dram_dq_in = !dram_cas_n ? mem[{row, col}] : ~lastd;
	assign prom_data  = !prom_cs_n ? {4'ha, prom_addr} : ~lastp;
endmodule : pdi_mem_model

// >>> verification/testbench.sv
// self-checking testbench of the processor dram interface
`timescale 1ns/1ps
bind pdi_dram_if pdi_chk #(.REFRESH_CYC(REFRESH_CYC)) u_pdi_chk (.mclk, .rst_b, .fault_clear,
	.refresh_ack, .mem_done, .mem_rdata, .protect_fault, .refresh_req, .clock_tick, .page_fault,
	.phase0_clock, .phase1_clock, .dram_ras_n, .dram_cas_n, .dram_we_n);
module testbench;
	import pdi_pkg::*;
	localparam int RCYC = 40;
	logic mclk, rst_b, mem_req, mem_write, byte_mode, byte_high, sign_extend, write_authorized;
	logic fault_clear, refresh_ack, mem_done, protect_fault, refresh_req, clock_tick, page_fault;
	logic phase0_clock, phase1_clock, dram_ras_n, dram_cas_n, dram_we_n, dram_dq_oe, prom_cs_n;
	logic [15:0]        mem_addr, mem_wdata, mem_rdata, dram_dq_in, prom_data, dram_dq_out, d;
	logic [ROW_W-1:0]   dram_addr;
	logic [PROM_AW-1:0] prom_addr;
	logic [16:0]        exp_q[$];
	logic [15:0]        pa[4] = '{16'h0010, 16'h0150, 16'h4000, 16'hf900};
	int                 fails, checks, n, seed = 32'h21983dc6;
	pdi_dram_if #(.REFRESH_CYC(RCYC)) u_pdi_dram_if (.mclk, .rst_b, .mem_req, .mem_write,
		.mem_addr, .mem_wdata, .byte_mode, .byte_high, .sign_extend, .write_authorized,
		.fault_clear, .refresh_ack, .dram_dq_in, .prom_data, .mem_done, .mem_rdata,
		.protect_fault, .refresh_req, .clock_tick, .page_fault, .phase0_clock, .phase1_clock,
		.dram_addr, .dram_ras_n, .dram_cas_n, .dram_we_n, .dram_dq_out, .dram_dq_oe,
		.prom_addr, .prom_cs_n);
	pdi_mem_model u_pdi_mem_model (.mclk, .dram_addr, .dram_ras_n, .dram_cas_n, .dram_we_n,
		.dram_dq_out, .prom_addr, .prom_cs_n, .dram_dq_in, .prom_data);
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	// ----
	// tasks
	// ----
	task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic cmpf(input logic got, input logic exp);
		cmp({15'h0, got}, {15'h0, exp});
	endtask : cmpf
	function automatic logic [15:0] ext(input logic [15:0] w, input logic bh, input logic sx);
		logic [7:0] b;
		b = bh ? w[15:8] : w[7:0];
		return {{8{sx & b[7]}}, b};
	endfunction : ext
	// request raised in T4, held until T1 of the access shows it was taken
	task automatic acc(input logic wr, input logic [15:0] a, input logic [15:0] wd,
		input logic bm, input logic bh, input logic sx, input logic au, input logic chk,
		input logic [15:0] ex);
		do begin @(posedge mclk); #1; end while (phase1_clock !== 1'b1);
		@(posedge mclk);
		#10 {mem_req, mem_write, byte_mode, byte_high, sign_extend, write_authorized} =
			{1'b1, wr, bm, bh, sx, au};
		mem_addr = a;
		mem_wdata = wd;
		exp_q.push_back({chk, ex});
		do begin @(posedge mclk); #1; end while (phase0_clock !== 1'b1);
		#9 mem_req = 1'b0;
	endtask : acc
	task automatic pulse(ref logic s);
		@(posedge mclk);
		#10 s = 1'b1;
		@(posedge mclk);
		#10 s = 1'b0;
	endtask : pulse
	task automatic conclude();
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask : conclude
	always @(posedge mclk) begin : mon
		logic [16:0] e;
		#1;
		if (mem_done === 1'b1 && exp_q.size() == 0) begin
			fails++;
			$display("unexpected at %0t: got %h expected %h", $time, mem_done, 1'b0);
		end else if (mem_done === 1'b1) begin
			e = exp_q.pop_front();
			if (e[16]) cmp(mem_rdata, e[15:0]);
		end
	end
	initial begin
		#500000 fails++;
		conclude();
	end
	// ----
	// scenarios
	// ----
	initial begin
		{mem_req, mem_write, byte_mode, byte_high, sign_extend} = 5'h0;
		{write_authorized, fault_clear, refresh_ack, rst_b} = 4'h0;
		mem_addr = 16'h0;
		mem_wdata = 16'h0;
		repeat (20) @(posedge mclk);
		#10 rst_b = 1'b1;
		d = 16'($random(seed));
		acc(1, 16'h0305, d, 0, 0, 0, 1, 0, 0);
		acc(0, 16'h0305, 0, 0, 0, 0, 0, 1, d);
		cmpf(page_fault, 1'b0);
		for (int i = 0; i < 4; i++) acc(0, 16'h0305, 0, 1, i[1], i[0], 0, 1, ext(d, i[1], i[0]));
		$display("test bytes done");
		// eighteen more page cycles take the open row just past its limit
		for (int i = 0; i < 18; i++) begin
			acc(0, 16'h0300 + 16'(i), 0, 0, 0, 0, 0, 0, 0);
			cmpf(page_fault, 1'b0);
		end
		acc(0, 16'h0305, 0, 0, 0, 0, 0, 1, d);
		cmpf(page_fault, 1'b1);
		$display("test dwell done");
		acc(1, 16'h0010, 16'h1234, 0, 0, 0, 1, 0, 0);
		cmpf(dram_dq_oe, 1'b1);
		acc(1, 16'h0150, 16'h5678, 0, 0, 0, 1, 0, 0);
		for (int i = 0; i < 4; i++) begin
			acc(1, pa[i], 16'($random(seed)), 0, 0, 0, 0, 0, 0);
			cmpf(protect_fault, 1'b1);
			cmpf(dram_dq_oe, 1'b0);
			pulse(fault_clear);
			cmpf(protect_fault, 1'b0);
		end
		acc(0, 16'h0010, 0, 0, 0, 0, 0, 1, 16'h1234);
		acc(0, 16'h0150, 0, 0, 0, 0, 0, 1, 16'h5678);
		acc(0, 16'h4000, 0, 0, 0, 0, 0, 1, 16'h0);
		acc(0, 16'hf900, 0, 0, 0, 0, 0, 1, 16'ha900);
		$display("test protect done");
		do begin @(posedge mclk); #1; end while (clock_tick !== 1'b1);
		n = 0;
		do begin @(posedge mclk); #1; n++; end while (clock_tick !== 1'b1 && n < 100);
		cmp(16'(n), 16'(RCYC));
		cmpf(refresh_req, 1'b1);
		pulse(refresh_ack);
		cmpf(refresh_req, 1'b0);
		for (int i = 0; i < 128; i++) begin
			acc(0, 16'(i) << 7, 0, 0, 0, 0, 0, 0, 0);
			cmpf(page_fault, 1'b1);
		end
		repeat (20) @(posedge mclk);
		cmp(16'(exp_q.size()), 16'h0);
		$display("test refresh done");
		conclude();
	end
endmodule : testbench
